// ==== core/wtm_params.svh ====
// Constants for the wordlength track mapper: offsets, fields, tags, reset values
`ifndef WTM_PARAMS_SVH
`define WTM_PARAMS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define WTM_CTRL_OFS 12'h000
`define WTM_STAT_OFS 12'h004
`define WTM_CTRL_RST 32'h0000_0000

// ****************************************
// Control field positions
// ****************************************
`define WTM_F_ENC_SEL 0
`define WTM_F_ENC_MEDIA 2
`define WTM_F_OUT_WL 4
`define WTM_F_DEC_SEL 6

// ****************************************
// Status field positions
// ****************************************
`define WTM_F_ENC_ACT 0
`define WTM_F_ENC_WIDE 1
`define WTM_F_DEC_ACT 2
`define WTM_F_DEC_WIDE 3
`define WTM_F_DEC_TM 4
`define WTM_F_TAG_BAD 7
`define WTM_F_NO_MEDIA 8

// ****************************************
// Track mode tag codes on medium channel 8
// ****************************************
`define WTM_TAG_NAT16 4'h9
`define WTM_TAG_SIX20 4'ha
`define WTM_TAG_FOUR24 4'hb
`define WTM_TAG_NAT20 4'hc
`define WTM_TAG_SIX24 4'hd

// ****************************************
// Range-enhancement knee (exact region edge)
// ****************************************
`define WTM_KNEE_SMP 24'h04_0000
`define WTM_KNEE_MED 20'h4_0000
`define WTM_RANGE_SHIFT 5

`endif

// ==== core/wtm_pkg.sv ====
// Types shared by the wordlength track mapper modules
package wtm_pkg;
   typedef enum logic [1:0] {
      WTM_SEL_OFF = 2'h0,
      WTM_SEL_MAP = 2'h1,
      WTM_SEL_RANGE = 2'h2,
      WTM_SEL_RSVD = 2'h3
   } wtm_sel_t;

   typedef enum logic [1:0] {
      WTM_MEDIA_NONE = 2'h0,
      WTM_MEDIA_NARROW = 2'h1,
      WTM_MEDIA_WIDE = 2'h2,
      WTM_MEDIA_RSVD = 2'h3
   } wtm_media_t;

   typedef enum logic [2:0] {
      WTM_TM_NONE = 3'h0,
      WTM_TM_NAT16 = 3'h1,
      WTM_TM_SIX20 = 3'h2,
      WTM_TM_FOUR24 = 3'h3,
      WTM_TM_NAT20 = 3'h4,
      WTM_TM_SIX24 = 3'h5
   } wtm_tm_t;
endpackage : wtm_pkg

// ==== core/wtm_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides and registered ready
`timescale 1ns/1ps
module wtm_fifo #(
   parameter int WIDTH = 192,
   parameter int DEPTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic push;
   logic pop;

   // ****************************************
   // Handshakes
   // ****************************************
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_valid = (count_r != '0);
   assign o_out_data = mem_r[rd_ptr_r];

   // Occupancy after this cycle
   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + CW'(1);
      end else if (pop && !push) begin
         count_nxt = count_r - CW'(1);
      end
   end

   // Pointers wrap only for power-of-two depths
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         o_in_ready <= 1'b0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
         if (pop) rd_ptr_r <= rd_ptr_r + AW'(1);
         count_r <= count_nxt;
         o_in_ready <= (count_nxt != FULL_CNT); // Registered so the top port is a flop
      end
   end

   // Storage has no reset; nothing reads a slot before it is written
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end
endmodule : wtm_fifo

// ==== core/wtm_chan.sv ====
// One channel: primary extraction and range-enhancement compand/expand
`timescale 1ns/1ps
`include "wtm_params.svh"
module wtm_chan (
   input wire logic i_wide,
   input wire logic i_range,
   input wire logic [23:0] i_smp,
   input wire logic [19:0] i_med,
   output logic [19:0] o_enc,
   output logic [23:0] o_dec
);
   logic [23:0] mag;
   logic [23:0] over;
   logic [19:0] cmag;
   logic [19:0] enc_raw;
   logic [19:0] dmag;
   logic [23:0] dval;

   // Compander: exact below the knee, 1:32 slope above it
   always_comb begin
      mag = i_smp[23] ? 24'(-i_smp) : i_smp;
      over = (mag - `WTM_KNEE_SMP) >> `WTM_RANGE_SHIFT;
      if (mag < `WTM_KNEE_SMP) begin
         cmag = mag[19:0];
      end else begin
         cmag = `WTM_KNEE_MED + over[19:0];
      end
      enc_raw = i_range ? (i_smp[23] ? 20'(-cmag) : cmag) : i_smp[23:4];
      // Narrow media keeps the top 16 bits of the left-justified word
      o_enc = i_wide ? enc_raw : {enc_raw[19:4], 4'h0};
   end

   // Expander is the same for both media since words are left-justified
   always_comb begin
      dmag = i_med[19] ? 20'(-i_med) : i_med;
      if (dmag < `WTM_KNEE_MED) begin
         dval = {4'h0, dmag};
      end else begin
         dval = `WTM_KNEE_SMP + 24'(({4'h0, dmag} - `WTM_KNEE_SMP) << `WTM_RANGE_SHIFT);
      end
      o_dec = i_med[19] ? 24'(-dval) : dval;
   end
endmodule : wtm_chan

// ==== core/wtm_mapper.sv ====
// Top of the wordlength track mapper: APB registers, encoder and decoder
// Function
// - Mapping encode needs explicit media variant
// - Track mode follows selected output wordlength
// - Auto decode picks variant and mode from tag
// - Primary holds top 16/20 bits, secondary rest
// - Six-channel: odd secondaries ch7, even ch8
// - Four-channel: secondary of n on n+4
// - Tag always on channel 8, read there
// - Encode indicator plus wide-media indicator
// - Decode indicator, wide only for wide stream
// - Range encode needs variant, wide indicator
// - Range decoder same for both variants
// - Range codec exact below knee on wide media
// - Narrow media: native, six 20, four 24
// - Wide media: native, six 24
// - Tag emitted in every mapping mode
// - Whole eight-channel bank coded together
`timescale 1ns/1ps
`include "wtm_params.svh"
module wtm_mapper
   import wtm_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_smp_valid,
   input wire logic [191:0] i_smp_data,
   output logic o_smp_ready,
   output logic o_med_valid,
   output logic [159:0] o_med_data,
   input wire logic i_med_ready,
   input wire logic i_med_in_valid,
   input wire logic [159:0] i_med_in_data,
   output logic o_dec_valid,
   output logic [191:0] o_dec_data,
   output logic o_enc_map_ind,
   output logic o_enc_range_ind,
   output logic o_enc_wide_media_indicator,
   output logic o_dec_map_ind,
   output logic o_dec_range_ind,
   output logic o_dec_wide_media_indicator
);
   logic [31:0] ctrl_r;
   logic tag_bad_r;
   wtm_tm_t dec_tm_r;
   wtm_sel_t enc_sel;
   wtm_media_t enc_media;
   wtm_sel_t dec_sel;
   logic [1:0] out_wl;
   wtm_tm_t enc_tm;
   logic enc_go;
   logic [3:0] enc_tag;
   logic fifo_valid;
   logic [191:0] fifo_data;
   logic enc_take;
   logic [23:0] smp [8];
   logic [19:0] prim [8];
   logic [19:0] medi [8];
   logic [23:0] rexp [8];
   logic [19:0] med_nxt [8];
   logic [23:0] dec_nxt [8];
   wtm_tm_t dec_tm;
   logic [3:0] rx_tag;
   logic apb_acc;
   logic [31:0] stat;

   // ****************************************
   // Control decode
   // ****************************************
   assign enc_sel = wtm_sel_t'(ctrl_r[`WTM_F_ENC_SEL +: 2]);
   assign enc_media = wtm_media_t'(ctrl_r[`WTM_F_ENC_MEDIA +: 2]);
   assign out_wl = ctrl_r[`WTM_F_OUT_WL +: 2];
   assign dec_sel = wtm_sel_t'(ctrl_r[`WTM_F_DEC_SEL +: 2]);
   // No default variant: encoding halts until one is chosen
   assign enc_go = ((enc_sel == WTM_SEL_MAP) || (enc_sel == WTM_SEL_RANGE)) &&
      ((enc_media == WTM_MEDIA_NARROW) || (enc_media == WTM_MEDIA_WIDE));

   // Track mode from media and wordlength: narrow 0=16, 1=20, 2/3=24 bits; wide 0/1=20, 2/3=24 bits
   always_comb begin
      enc_tm = WTM_TM_NONE;
      if (enc_sel == WTM_SEL_MAP && enc_media == WTM_MEDIA_NARROW) begin
         case (out_wl)
            2'h0: enc_tm = WTM_TM_NAT16;
            2'h1: enc_tm = WTM_TM_SIX20;
            default: enc_tm = WTM_TM_FOUR24;
         endcase
      end else if (enc_sel == WTM_SEL_MAP && enc_media == WTM_MEDIA_WIDE) begin
         enc_tm = out_wl[1] ? WTM_TM_SIX24 : WTM_TM_NAT20;
      end
   end

   // Tag code per track mode
   always_comb begin
      case (enc_tm)
         WTM_TM_NAT16: enc_tag = `WTM_TAG_NAT16;
         WTM_TM_SIX20: enc_tag = `WTM_TAG_SIX20;
         WTM_TM_FOUR24: enc_tag = `WTM_TAG_FOUR24;
         WTM_TM_NAT20: enc_tag = `WTM_TAG_NAT20;
         WTM_TM_SIX24: enc_tag = `WTM_TAG_SIX24;
         default: enc_tag = 4'h0;
      endcase
   end

   // ****************************************
   // Sample FIFO and per-channel datapath
   // ****************************************
   wtm_fifo #(.WIDTH(192), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_in_valid(i_smp_valid),
      .i_in_data(i_smp_data),
      .o_in_ready(o_smp_ready),
      .o_out_valid(fifo_valid),
      .o_out_data(fifo_data),
      .i_out_ready(enc_take)
   );

   // Output stage stalls the FIFO until the medium accepts the bank
   assign enc_take = enc_go && fifo_valid && (!o_med_valid || i_med_ready);

   for (genvar c = 0; c < 8; c++) begin : g_chan
      assign smp[c] = fifo_data[c*24 +: 24];
      assign medi[c] = i_med_in_data[c*20 +: 20];
      wtm_chan u_chan (
         .i_wide(enc_media == WTM_MEDIA_WIDE),
         .i_range(enc_sel == WTM_SEL_RANGE),
         .i_smp(smp[c]),
         .i_med(medi[c]),
         .o_enc(prim[c]),
         .o_dec(rexp[c])
      );
   end

   // Bank mapping: slots [19:16],[15:12],[11:8], tag at [7:4] of channel 8
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         med_nxt[c] = prim[c];
      end
      case (enc_tm)
         WTM_TM_SIX20: begin
            med_nxt[6] = {smp[0][7:4], smp[2][7:4], smp[4][7:4], 8'h00};
            med_nxt[7] = {smp[1][7:4], smp[3][7:4], smp[5][7:4], enc_tag, 4'h0};
         end
         WTM_TM_SIX24: begin
            med_nxt[6] = {smp[0][3:0], smp[2][3:0], smp[4][3:0], 8'h00};
            med_nxt[7] = {smp[1][3:0], smp[3][3:0], smp[5][3:0], enc_tag, 4'h0};
         end
         WTM_TM_FOUR24: begin
            med_nxt[4] = {smp[0][7:0], 12'h000};
            med_nxt[5] = {smp[1][7:0], 12'h000};
            med_nxt[6] = {smp[2][7:0], 12'h000};
            med_nxt[7] = {smp[3][7:0], 4'h0, enc_tag, 4'h0};
         end
         WTM_TM_NAT16, WTM_TM_NAT20: begin
            med_nxt[7] = {prim[7][19:8], enc_tag, prim[7][3:0]};
         end
         default: begin
         end
      endcase
   end

   // ****************************************
   // Encoder output register
   // ****************************************
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_med_valid <= 1'b0;
         o_med_data <= '0;
      end else begin
         if (enc_take) begin
            o_med_valid <= 1'b1;
            for (int c = 0; c < 8; c++) begin
               o_med_data[c*20 +: 20] <= med_nxt[c];
            end
         end else if (i_med_ready) begin
            o_med_valid <= 1'b0;
         end
      end
   end

   // ****************************************
   // Decoder: mode from the channel 8 tag
   // ****************************************
   assign rx_tag = medi[7][7:4];

   always_comb begin
      case (rx_tag)
         `WTM_TAG_NAT16: dec_tm = WTM_TM_NAT16;
         `WTM_TAG_SIX20: dec_tm = WTM_TM_SIX20;
         `WTM_TAG_FOUR24: dec_tm = WTM_TM_FOUR24;
         `WTM_TAG_NAT20: dec_tm = WTM_TM_NAT20;
         `WTM_TAG_SIX24: dec_tm = WTM_TM_SIX24;
         default: dec_tm = WTM_TM_NONE;
      endcase
   end

   // Rebuild: primary as the upper part, secondary below it
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         dec_nxt[c] = 24'h00_0000;
      end
      if (dec_sel == WTM_SEL_RANGE) begin
         for (int c = 0; c < 8; c++) begin
            dec_nxt[c] = rexp[c];
         end
      end else begin
         case (dec_tm)
            WTM_TM_NAT16: begin
               for (int c = 0; c < 8; c++) dec_nxt[c] = {medi[c][19:4], 8'h00};
            end
            WTM_TM_NAT20: begin
               for (int c = 0; c < 8; c++) dec_nxt[c] = {medi[c], 4'h0};
            end
            WTM_TM_SIX20: begin
               for (int c = 0; c < 3; c++) begin
                  dec_nxt[2*c] = {medi[2*c][19:4], medi[6][19-4*c -: 4], 4'h0};
                  dec_nxt[2*c+1] = {medi[2*c+1][19:4], medi[7][19-4*c -: 4], 4'h0};
               end
            end
            WTM_TM_SIX24: begin
               for (int c = 0; c < 3; c++) begin
                  dec_nxt[2*c] = {medi[2*c], medi[6][19-4*c -: 4]};
                  dec_nxt[2*c+1] = {medi[2*c+1], medi[7][19-4*c -: 4]};
               end
            end
            WTM_TM_FOUR24: begin
               for (int c = 0; c < 4; c++) dec_nxt[c] = {medi[c][19:4], medi[c+4][19:12]};
            end
            default: begin
            end
         endcase
      end
   end

   // Decoder output and mode register; a dropped track shows as a bad tag
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dec_valid <= 1'b0;
         o_dec_data <= '0;
         dec_tm_r <= WTM_TM_NONE;
         tag_bad_r <= 1'b0;
      end else begin
         o_dec_valid <= i_med_in_valid && (dec_sel == WTM_SEL_MAP || dec_sel == WTM_SEL_RANGE);
         if (i_med_in_valid) begin
            for (int c = 0; c < 8; c++) begin
               o_dec_data[c*24 +: 24] <= dec_nxt[c];
            end
            dec_tm_r <= (dec_sel == WTM_SEL_MAP) ? dec_tm : WTM_TM_NONE;
            tag_bad_r <= (dec_sel == WTM_SEL_MAP) && (dec_tm == WTM_TM_NONE);
         end
      end
   end

   // ****************************************
   // Front-panel style indicators
   // ****************************************
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_enc_map_ind <= 1'b0;
         o_enc_range_ind <= 1'b0;
         o_enc_wide_media_indicator <= 1'b0;
         o_dec_map_ind <= 1'b0;
         o_dec_range_ind <= 1'b0;
         o_dec_wide_media_indicator <= 1'b0;
      end else begin
         o_enc_map_ind <= enc_go && (enc_sel == WTM_SEL_MAP);
         o_enc_range_ind <= enc_go && (enc_sel == WTM_SEL_RANGE);
         o_enc_wide_media_indicator <= enc_go && (enc_media == WTM_MEDIA_WIDE);
         o_dec_map_ind <= (dec_sel == WTM_SEL_MAP);
         o_dec_range_ind <= (dec_sel == WTM_SEL_RANGE);
         // Wide only when the stream itself says so, never for range decode
         o_dec_wide_media_indicator <= (dec_sel == WTM_SEL_MAP) &&
            (dec_tm_r == WTM_TM_NAT20 || dec_tm_r == WTM_TM_SIX24);
      end
   end

   // ****************************************
   // APB slave, one wait state per access
   // ****************************************
   assign apb_acc = i_psel && i_penable;

   always_comb begin
      stat = 32'h0000_0000;
      stat[`WTM_F_ENC_ACT] = o_enc_map_ind || o_enc_range_ind;
      stat[`WTM_F_ENC_WIDE] = o_enc_wide_media_indicator;
      stat[`WTM_F_DEC_ACT] = o_dec_map_ind || o_dec_range_ind;
      stat[`WTM_F_DEC_WIDE] = o_dec_wide_media_indicator;
      stat[`WTM_F_DEC_TM +: 3] = dec_tm_r;
      stat[`WTM_F_TAG_BAD] = tag_bad_r;
      stat[`WTM_F_NO_MEDIA] = (enc_sel != WTM_SEL_OFF) && !enc_go;
   end

   // Ready rises one edge into the access phase; the write lands on the next edge, where ready is sampled
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= apb_acc && !o_pready;
         if (apb_acc && !o_pready) begin
            o_pslverr <= (i_paddr != `WTM_CTRL_OFS) && (i_paddr != `WTM_STAT_OFS);
            if (i_paddr == `WTM_CTRL_OFS) o_prdata <= {24'h00_0000, ctrl_r[7:0]};
            else if (i_paddr == `WTM_STAT_OFS) o_prdata <= stat;
            else o_prdata <= 32'h0000_0000;
         end
      end
   end

   // Control register, only the low byte is writable
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= `WTM_CTRL_RST;
      end else if (apb_acc && o_pready && i_pwrite && i_paddr == `WTM_CTRL_OFS) begin
         ctrl_r <= {24'h00_0000, i_pwdata[7:0]};
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   // A bank launched earlier may still wait on the medium, so only new launches are barred
   a_no_default_variant: assert property ((enc_sel == WTM_SEL_MAP && enc_media == WTM_MEDIA_NONE) |->
      !enc_take ##1 !o_enc_map_ind) else $error("encoder ran without a media variant");
   a_wide_needs_active: assert property (o_enc_wide_media_indicator |->
      (o_enc_map_ind || o_enc_range_ind) && $past(enc_media == WTM_MEDIA_WIDE))
      else $error("wide indicator without encoding");
   a_primary_top_bits: assert property ((enc_take && enc_tm == WTM_TM_SIX20) |=>
      o_med_data[19:4] == $past(fifo_data[23:8])) else $error("primary bits wrong");
   a_four_secondary: assert property ((enc_take && enc_tm == WTM_TM_FOUR24) |=>
      o_med_data[99:92] == $past(fifo_data[7:0])) else $error("secondary not on channel n+4");
   a_tag_on_eight: assert property ((enc_take && enc_tm == WTM_TM_NAT20) |=>
      o_med_data[147:144] == `WTM_TAG_NAT20) else $error("tag missing on channel 8");
   a_six_odd_slot: assert property ((enc_take && enc_tm == WTM_TM_SIX24) |=>
      o_med_data[139:136] == $past(fifo_data[3:0])) else $error("odd secondary misplaced");
   a_dec_rebuild: assert property ((i_med_in_valid && dec_sel == WTM_SEL_MAP && rx_tag == `WTM_TAG_SIX24)
      |=> o_dec_valid && o_dec_data[23:0] == {$past(i_med_in_data[19:0]), $past(i_med_in_data[139:136])})
      else $error("six-channel rebuild wrong");
   a_dec_wide_flag: assert property ((i_med_in_valid && dec_sel == WTM_SEL_MAP && rx_tag == `WTM_TAG_NAT16)
      ##1 (dec_sel == WTM_SEL_MAP) |=> !o_dec_wide_media_indicator) else $error("wide shown for narrow stream");
   a_range_dec_narrow: assert property ((dec_sel == WTM_SEL_RANGE)[*2] |->
      !o_dec_wide_media_indicator) else $error("range decode shows a variant");
   a_apb_wait: assert property ((apb_acc && !o_pready) |=> o_pready ##1 !o_pready)
      else $error("pready not a one-cycle answer");
endmodule : wtm_mapper

// ==== test/wtm_medium_model.sv ====
// Behavioural eight-channel recorder that replays every accepted bank
`timescale 1ns/1ps
module wtm_medium_model (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_med_valid,
   input wire logic [159:0] i_med_data,
   output logic o_med_ready,
   output logic o_in_valid,
   output logic [159:0] o_in_data
);
   logic [2:0] cnt_r;
   // Stall one cycle in eight so the encoder must hold its bank
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 3'h0;
         o_med_ready <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 3'h1;
         o_med_ready <= (cnt_r != 3'h5);
      end
   end
   // Replay all eight channels intact; released lines show inverted data
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_in_valid <= 1'b0;
         o_in_data <= 160'h0;
      end else if (i_med_valid && o_med_ready) begin
         o_in_valid <= 1'b1;
         o_in_data <= i_med_data;
      end else begin
         o_in_valid <= 1'b0;
         o_in_data <= ~o_in_data;
      end
   end
endmodule : wtm_medium_model

// ==== test/tb_top.sv ====
// Self-checking bench for the wordlength track mapper
`timescale 1ns/1ps
module tb_top;
   import wtm_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, sv = 1'b0, s_rdy, mv, m_rdy, iv, dv;
   logic [191:0] sd, dd;
   logic [159:0] md, id;
   logic e_map, e_rng, e_wide, d_map, d_rng, d_wide;
   int errors = 0, cmp_count = 0;
   // 250 MHz system clock
   always #2 clk = ~clk;
   wtm_mapper #(.FIFO_DEPTH(8)) dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_smp_valid(sv), .i_smp_data(sd), .o_smp_ready(s_rdy),
      .o_med_valid(mv), .o_med_data(md), .i_med_ready(m_rdy), .i_med_in_valid(iv), .i_med_in_data(id),
      .o_dec_valid(dv), .o_dec_data(dd), .o_enc_map_ind(e_map), .o_enc_range_ind(e_rng),
      .o_enc_wide_media_indicator(e_wide), .o_dec_map_ind(d_map), .o_dec_range_ind(d_rng),
      .o_dec_wide_media_indicator(d_wide));
   wtm_medium_model med_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_med_valid(mv), .i_med_data(md),
      .o_med_ready(m_rdy), .o_in_valid(iv), .o_in_data(id));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic close_out();
      $display("tests done: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic hang();
      errors++;
      $display("mismatch at %0t: wait ran out", $time);
      close_out();
   endtask : hang
   // One APB transfer; request held until the edge that samples pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (++n > 50) hang();
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic push();
      int n;
      @(posedge clk);
      sv <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         if (++n > 200) hang();
      end while (s_rdy !== 1'b1);
      @(posedge clk);
      sv <= 0;
   endtask : push
   // Catch the replayed bank, then the decoded bank one cycle later
   task automatic wait_med(output logic [159:0] enc, output logic [191:0] dec);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         if (++n > 200) hang();
      end while (iv !== 1'b1);
      enc = id;
      @(negedge clk);
      chk(32'(dv), 32'h1);
      dec = dd;
   endtask : wait_med
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      logic [31:0] rd;
      logic err;
      apb(1'b0, 12'h000, 32'h0, rd, err);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0, rd, err);
      chk({rd[30:0], err}, 32'h1);
      $display("test regs done");
   endtask : t_regs
   // No media variant: encoder must not run, so the FIFO fills
   task automatic t_fill();
      logic [31:0] rd;
      logic err;
      int cnt;
      apb(1'b1, 12'h000, 32'h41, rd, err);
      repeat (8) push();
      repeat (2) @(negedge clk);
      chk(32'(s_rdy), 32'h0);
      apb(1'b0, 12'h004, 32'h0, rd, err);
      chk(32'(rd[8]), 32'h1);
      apb(1'b1, 12'h000, 32'h65, rd, err);
      cnt = 0;
      repeat (200) begin
         @(negedge clk);
         if (dv === 1'b1) cnt++;
      end
      chk(cnt, 32'h8);
      $display("test fill done");
   endtask : t_fill
   task automatic t_map(input logic [1:0] mda, input logic [1:0] wl, input logic [3:0] tag, input int bits,
                        input logic [2:0] tm);
      logic [159:0] enc;
      logic [191:0] dec;
      logic [23:0] s, t;
      logic [31:0] rd;
      logic err;
      apb(1'b1, 12'h000, {24'h0, 2'h1, wl, mda, 2'h1}, rd, err);
      push();
      wait_med(enc, dec);
      for (int c = 0; c < 4; c++) begin
         s = sd[c*24+:24];
         chk(32'(dec[c*24+:24]), 32'(s & ~((24'h1 << (24 - bits)) - 24'h1)));
         chk(32'(enc[c*20+:20]), 32'(mda == 2'h1 ? {s[23:8], 4'h0} : s[23:4]));
      end
      chk(32'(enc[144+:4]), 32'(tag));
      s = sd[23:0];
      t = sd[47:24];
      if (tm == WTM_TM_FOUR24) chk(32'(enc[92+:8]), 32'(s[7:0]));
      if (tm == WTM_TM_SIX20 || tm == WTM_TM_SIX24) begin
         chk(32'(enc[136+:4]), 32'(mda == 2'h1 ? s[7:4] : s[3:0]));
         chk(32'(enc[156+:4]), 32'(mda == 2'h1 ? t[7:4] : t[3:0]));
      end
      repeat (2) @(negedge clk);
      chk(32'({e_map, e_wide, d_map, d_wide}), {28'h0, 1'b1, mda == 2'h2, 1'b1, mda == 2'h2});
      apb(1'b0, 12'h004, 32'h0, rd, err);
      chk(32'(rd[6:4]), 32'(tm));
      $display("test map %0d done", tm);
   endtask : t_map
   // Quiet samples stay below the knee and must come back exactly, less the low nibble on narrow media
   task automatic t_range(input logic [1:0] mda);
      logic [159:0] enc;
      logic [191:0] dec;
      logic [31:0] rd;
      logic err;
      apb(1'b1, 12'h000, {24'h0, 2'h2, 2'h2, mda, 2'h2}, rd, err);
      push();
      wait_med(enc, dec);
      // Narrow media carries only the top 16 of the 20 bits, so the low nibble is lost
      for (int c = 0; c < 8; c++) begin
         chk(32'(dec[c*24+:24]), 32'(sd[c*24+:24] & (mda == 2'h1 ? 24'hff_fff0 : 24'hff_ffff)));
      end
      repeat (2) @(negedge clk);
      chk(32'({e_rng, e_wide, d_rng}), {29'h0, 1'b1, mda == 2'h2, 1'b1});
      $display("test range %0d done", mda);
   endtask : t_range
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      for (int c = 0; c < 8; c++) sd[c*24+:24] <= 24'h012345 + 24'(c) * 24'h001111;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_fill();
      t_map(2'h1, 2'h0, 4'h9, 16, WTM_TM_NAT16);
      t_map(2'h1, 2'h1, 4'ha, 20, WTM_TM_SIX20);
      t_map(2'h1, 2'h2, 4'hb, 24, WTM_TM_FOUR24);
      t_map(2'h2, 2'h1, 4'hc, 20, WTM_TM_NAT20);
      t_map(2'h2, 2'h2, 4'hd, 24, WTM_TM_SIX24);
      t_range(2'h1);
      t_range(2'h2);
      close_out();
   end
endmodule : tb_top
